//--- common/sdt_pkg.sv
// register map, field layout and mode codes of the standard timer
package sdt_pkg;
    localparam int          ADDR_W    = 8;
    localparam int          DATA_W    = 32;
    localparam int          CNT_W     = 10;
    // register byte addresses
    localparam logic [7:0]  OFS_CTRL0 = 8'h00;
    localparam logic [7:0]  OFS_CTRL1 = 8'h04;
    localparam logic [7:0]  OFS_COUNT = 8'h08;
    localparam logic [7:0]  OFS_CMPAL = 8'h0C;
    localparam logic [7:0]  OFS_CMPAH = 8'h10;
    localparam logic [7:0]  OFS_FLAGS = 8'h14;
    // control 0 fields
    localparam int          C0_RUN    = 3;
    localparam int          C0_CVP_LO = 0;
    // control 1 fields
    localparam int          C1_CLR    = 0;
    localparam int          C1_SWAP   = 1;
    localparam int          C1_INV    = 2;
    localparam int          C1_OLC    = 3;
    localparam int          C1_FN_LO  = 4;
    localparam int          C1_MD_LO  = 6;
    // flag fields
    localparam int          FL_A      = 0;
    localparam int          FL_P      = 1;
    // reset values
    localparam logic [7:0]  CTRL0_RST = 8'h00;
    localparam logic [7:0]  CTRL1_RST = 8'h00;
    localparam logic [9:0]  CVA_RST   = 10'h000;
    localparam logic [9:0]  CNT_RST   = 10'h000;
    // comparator P weight: 3-bit value against count bits 9..7
    localparam int          P_SHIFT   = 7;
    // bus answers
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLV  = 2'h2;
    // pin function codes
    localparam logic [1:0]  FN_00     = 2'h0;
    localparam logic [1:0]  FN_01     = 2'h1;
    localparam logic [1:0]  FN_10     = 2'h2;
    localparam logic [1:0]  FN_11     = 2'h3;
    typedef enum logic [1:0] {
        SDT_CMP = 2'b00,
        SDT_CAP = 2'b01,
        SDT_PWM = 2'b10,
        SDT_TC  = 2'b11
    } sdt_mode_t;
endpackage : sdt_pkg

//--- rtl/sdt_top.sv
// standard timer: 10-bit counter, two comparators, axi4-lite registers
// Functional notes
// - mode field 00 selects compare match output mode.
// - clear select low: clear on P match or overflow, both flags.
// - clear select high: clear on A match, only the A flag.
// - compare mode, A zero: count to 3FF, overflow, no A flag.
// - compare mode pin moves on A match per pin function and on run rise.
// - rising run bit loads the pin with the initial level.
// - mode 11 counts like compare mode but releases the pin.
// - PWM: swap low, P is period in 128s, A duty; high swaps.
// - PWM duty at or above period gives full duty.
// - PWM: each match raises own flag; clear select ignored.
// - PWM polarity, inversion, and forced levels for functions 00/01.
// - single pulse starts on run rise, software or external edge.
// - pulse ends on run clear or A match, which flags.
// - single pulse: count zeroed only by run rise; P ignored.
// - mode 01 is capture mode; counter starts on run rise.
// - capture edge copies count into compare A and flags.
// - capture counter free runs; P match clears and flags.
// - capture function 11 disables capture, counter still runs.
// - capture ignores clear, swap, level, invert; no pin drive.
// - compare A high register holds bits 9..8, rest zero.
// - run rise zeroes the counter, run fall freezes it.
// - P compares against count bits 9..7, 128-clock steps.
// - capture edge: 00 rise, 01 fall, 10 both, 11 off.
`timescale 1ns/1ps
module sdt_top (
    input  wire logic                       clk,     // module clock
    input  wire logic                       rst_n,   // sync reset
    input  wire logic                       ce,      // clock enable
    input  wire logic [sdt_pkg::ADDR_W-1:0] awaddr,  // write address
    input  wire logic                       awvalid, // write addr valid
    output logic                            awready, // write addr ready
    input  wire logic [sdt_pkg::DATA_W-1:0] wdata,   // write data
    input  wire logic [3:0]                 wstrb,   // byte enables
    input  wire logic                       wvalid,  // write data valid
    output logic                            wready,  // write data ready
    output logic [1:0]                      bresp,   // write answer
    output logic                            bvalid,  // write answer valid
    input  wire logic                       bready,  // answer taken
    input  wire logic [sdt_pkg::ADDR_W-1:0] araddr,  // read address
    input  wire logic                       arvalid, // read addr valid
    output logic                            arready, // read addr ready
    output logic [sdt_pkg::DATA_W-1:0]      rdata,   // read data
    output logic [1:0]                      rresp,   // read answer
    output logic                            rvalid,  // read data valid
    input  wire logic                       rready,  // read data taken
    input  wire logic                       capture_input_pin,  // capture
    input  wire logic                       external_clock_pin, // trigger
    output logic                            timer_out,    // output pin
    output logic                            timer_out_en  // pin driven
);
    import sdt_pkg::*;

    logic       counter_run;
    logic [2:0] compare_value_p;
    logic [1:0] mode_sel;
    logic [1:0] pin_function_select;
    logic       output_level_control;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_source_select;
    logic [9:0] compare_value_a;
    logic       match_a_flag;
    logic       match_p_flag;
    logic [9:0] count;
    logic       run_q;
    logic       out_state;
    logic       ext_q;
    logic       cap_q;
    logic       wr_rdy;
    logic       rd_rdy;

    // 3-bit P value widened to an 11-bit target, zero meaning 1024
    function automatic logic [10:0] p_span(input logic [2:0] v);
        p_span = {(v == 3'h0), v, 7'h00};
    endfunction : p_span

    // register address decode shared by both bus channels
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == OFS_CTRL0) || (a == OFS_CTRL1) ||
                  (a == OFS_COUNT) || (a == OFS_CMPAL) ||
                  (a == OFS_CMPAH) || (a == OFS_FLAGS);
    endfunction : reg_hit

    // mode decode
    logic is_cmp;
    logic is_tc;
    logic is_cap;
    logic is_pwmf;
    logic is_pulse;
    logic is_pwm;
    assign is_cmp   = mode_sel == SDT_CMP;
    assign is_tc    = mode_sel == SDT_TC;
    assign is_cap   = mode_sel == SDT_CAP;
    assign is_pwmf  = mode_sel == SDT_PWM;
    assign is_pulse = is_pwmf && (pin_function_select == FN_11);
    assign is_pwm   = is_pwmf && !is_pulse;

    // counter stepping and comparator hits on the value about to be reached
    logic        run_rise;
    logic        adv;
    logic [10:0] inc;
    logic [10:0] a_target;
    logic [10:0] p_target;
    logic        a_hit;
    logic        p_hit;
    assign run_rise = counter_run && !run_q;
    assign adv      = counter_run && run_q;
    assign inc      = {1'b0, count} + 11'h001;
    assign a_target = {(compare_value_a == 10'h000), compare_value_a};
    assign p_target = p_span(compare_value_p);
    assign a_hit    = adv && (inc == a_target) &&
                      (is_pwmf || compare_value_a != 10'h000);
    assign p_hit    = adv && (inc == p_target);

    // clear source per mode
    logic clr_hit;
    assign clr_hit = (is_cmp || is_tc) ?
                         (clear_source_select ? a_hit : p_hit) :
                     is_pwm ? (period_duty_swap ? a_hit : p_hit) :
                     is_cap ? p_hit : 1'b0;

    // capture edge selection
    logic cap_rise;
    logic cap_fall;
    logic cap_edge;
    logic cap_event;
    assign cap_rise  = capture_input_pin && !cap_q;
    assign cap_fall  = !capture_input_pin && cap_q;
    assign cap_edge  = (pin_function_select == FN_00) ? cap_rise :
                       (pin_function_select == FN_01) ? cap_fall :
                       (pin_function_select == FN_10) ?
                           (cap_rise || cap_fall) : 1'b0;
    assign cap_event = is_cap && counter_run && cap_edge;

    // flag sources
    logic set_a;
    logic set_p;
    assign set_a = (a_hit && !is_cap) || cap_event;
    assign set_p = p_hit && !is_pulse &&
                   !((is_cmp || is_tc) && clear_source_select);

    // external edge starts a single pulse
    logic ext_rise;
    assign ext_rise = external_clock_pin && !ext_q;

    // pwm period, duty and pin level
    logic [10:0] period;
    logic [10:0] duty;
    logic        pwm_active;
    logic        pwm_lvl;
    assign period     = period_duty_swap ? a_target : p_target;
    assign duty       = period_duty_swap ? p_target :
                        {1'b0, compare_value_a};
    assign pwm_active = (duty >= period) || ({1'b0, count} < duty);
    assign pwm_lvl    = (pin_function_select == FN_01) ? 1'b1 :
                        (pin_function_select == FN_10) ? pwm_active :
                        1'b0;

    // pin composition
    logic next_pin;
    logic next_oe;
    assign next_pin = is_cmp ? (out_state ^ output_invert) :
                      is_pulse ? ((counter_run ? output_level_control :
                          !output_level_control) ^ output_invert) :
                      is_pwm ? ((pwm_lvl ? output_level_control :
                          !output_level_control) ^ output_invert) :
                      1'b0;
    assign next_oe  = is_cmp || is_pwmf;

    // bus write decode
    logic wr_fire;
    logic wr_lo;
    logic rd_fire;
    assign wr_fire = wr_rdy && awvalid && wvalid;
    assign wr_lo   = wr_fire && wstrb[0] && reg_hit(awaddr);
    assign rd_fire = rd_rdy && arvalid;

    // read data selection
    logic [31:0] rd_word;
    assign rd_word =
        (araddr == OFS_CTRL0) ? {28'h000_0000, counter_run,
                                 compare_value_p} :
        (araddr == OFS_CTRL1) ? {24'h00_0000, mode_sel,
                                 pin_function_select, output_level_control,
                                 output_invert, period_duty_swap,
                                 clear_source_select} :
        (araddr == OFS_COUNT) ? {22'h00_0000, count} :
        (araddr == OFS_CMPAL) ? {24'h00_0000, compare_value_a[7:0]} :
        (araddr == OFS_CMPAH) ? {30'h0000_0000,
                                 compare_value_a[9:8]} :
        (araddr == OFS_FLAGS) ? {30'h0000_0000, match_p_flag,
                                 match_a_flag} : 32'h0000_0000;

    // axi write channel: take address and data together, then answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_rdy <= 1'b0;
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (ce) begin
            wr_rdy <= !wr_rdy && !bvalid && awvalid && wvalid;
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp  <= reg_hit(awaddr) ? RESP_OKAY : RESP_SLV;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    assign awready = wr_rdy;
    assign wready  = wr_rdy;

    // axi read channel
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_rdy <= 1'b0;
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (ce) begin
            rd_rdy <= !rd_rdy && !rvalid && arvalid;
            if (rd_fire) begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= reg_hit(araddr) ? RESP_OKAY : RESP_SLV;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end
    assign arready = rd_rdy;

    // control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {mode_sel, pin_function_select, output_level_control,
             output_invert, period_duty_swap,
             clear_source_select} <= CTRL1_RST;
            compare_value_p <= CTRL0_RST[2:0];
        end else if (ce && wr_lo && awaddr == OFS_CTRL1) begin
            mode_sel             <= wdata[C1_MD_LO+:2];
            pin_function_select  <= wdata[C1_FN_LO+:2];
            output_level_control <= wdata[C1_OLC];
            output_invert        <= wdata[C1_INV];
            period_duty_swap     <= wdata[C1_SWAP];
            clear_source_select  <= wdata[C1_CLR];
        end else if (ce && wr_lo && awaddr == OFS_CTRL0) begin
            compare_value_p <= wdata[C0_CVP_LO+:3];
        end
    end

    // run bit: software write, external trigger set, pulse-end clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            counter_run <= CTRL0_RST[C0_RUN];
        end else if (ce) begin
            if (wr_lo && awaddr == OFS_CTRL0) begin
                counter_run <= wdata[C0_RUN];
            end else if (is_pulse && a_hit) begin
                counter_run <= 1'b0;
            end else if (is_pulse && ext_rise) begin
                counter_run <= 1'b1;
            end
        end
    end

    // compare value A: capture overrides a software write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            compare_value_a <= CVA_RST;
        end else if (ce) begin
            if (cap_event) begin
                compare_value_a <= count;
            end else if (wr_lo && awaddr == OFS_CMPAL) begin
                compare_value_a[7:0] <= wdata[7:0];
            end else if (wr_lo && awaddr == OFS_CMPAH) begin
                compare_value_a[9:8] <= wdata[1:0];
            end
        end
    end

    // sticky flags, hardware set beats write-one clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end else if (ce) begin
            match_a_flag <= set_a || (match_a_flag &&
                !(wr_lo && awaddr == OFS_FLAGS && wdata[FL_A]));
            match_p_flag <= set_p || (match_p_flag &&
                !(wr_lo && awaddr == OFS_FLAGS && wdata[FL_P]));
        end
    end

    // counter and edge history
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= CNT_RST;
            run_q <= 1'b0;
            ext_q <= 1'b0;
            cap_q <= 1'b0;
        end else if (ce) begin
            run_q <= counter_run;
            ext_q <= external_clock_pin;
            cap_q <= capture_input_pin;
            if (run_rise) begin
                count <= CNT_RST;
            end else if (adv) begin
                count <= clr_hit ? CNT_RST : inc[9:0];
            end
        end
    end

    // compare-mode pin state and registered pin outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_state    <= 1'b0;
            timer_out    <= 1'b0;
            timer_out_en <= 1'b0;
        end else if (ce) begin
            timer_out    <= next_pin;
            timer_out_en <= next_oe;
            if (run_rise) begin
                out_state <= output_level_control;
            end else if (is_cmp && a_hit) begin
                case (pin_function_select)
                    FN_01:   out_state <= 1'b0;
                    FN_10:   out_state <= 1'b1;
                    FN_11:   out_state <= !out_state;
                    default: out_state <= out_state;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    sequence s_trig;
        is_pulse && !counter_run && ext_rise && !wr_fire;
    endsequence

    chk_run_rise_zero: assert property (
        run_rise |=> count == 10'h000) else $error("no zero on run rise");
    chk_run_low_hold: assert property (
        !counter_run |=> $stable(count)) else $error("count moved stopped");
    chk_cmp_zero_a: assert property (
        (is_cmp || is_tc) && compare_value_a == 10'h000 && !match_a_flag
        |=> !match_a_flag) else $error("A flag with A zero");
    chk_clr_a_nop: assert property (
        (is_cmp || is_tc) && clear_source_select && !match_p_flag
        |=> !match_p_flag) else $error("P flag with A clear");
    chk_p_clear_both: assert property (
        adv && is_cmp && !clear_source_select && inc == p_target &&
        !wr_fire |=> count == 10'h000 && match_p_flag)
        else $error("P match did not clear");
    chk_cmp_toggle_pin: assert property (
        is_cmp && a_hit && pin_function_select == FN_11 && !wr_fire
        |=> out_state != $past(out_state) ##1
            timer_out == $past(out_state ^ output_invert))
        else $error("toggle missed");
    chk_pwm_full_duty: assert property (
        is_pwm && pin_function_select == FN_10 && duty >= period
        |=> timer_out == $past(output_level_control ^ output_invert))
        else $error("full duty lost");
    chk_pulse_end_a: assert property (
        is_pulse && a_hit && !wr_fire |=> !counter_run && match_a_flag)
        else $error("pulse not ended");
    chk_ext_trigger: assert property (
        s_trig |=> counter_run ##1 (count == 10'h000 &&
            timer_out == $past(output_level_control ^ output_invert)))
        else $error("trigger failed");
    chk_capture_copy: assert property (
        cap_event |=> compare_value_a == $past(count) && match_a_flag)
        else $error("capture lost");
    chk_cap_off: assert property (
        is_cap && pin_function_select == FN_11 && !wr_fire
        |=> $stable(compare_value_a)) else $error("capture while off");
    chk_pin_release: assert property (
        is_cap || is_tc |=> !timer_out_en) else $error("pin driven");
endmodule : sdt_top

//--- tb/sdt_partner.sv
// pin-side model: pulse source for the inputs, load counting high cycles
`timescale 1ns/1ps
module sdt_partner (
    input  wire logic clk,                // module clock
    input  wire logic timer_out,          // pin level seen by the load
    input  wire logic timer_out_en,       // pin driven
    output logic      capture_input_pin,  // capture source
    output logic      external_clock_pin  // trigger source
);
    int high_cnt;
    initial begin
        capture_input_pin = 1'b0;
        external_clock_pin = 1'b0;
        high_cnt = 0;
    end
    // load: count cycles in which the pin is driven high
    always @(posedge clk) begin
        if (timer_out_en && timer_out)
            high_cnt <= high_cnt + 1;
    end
    // one three-cycle high pulse, both edges seen by the synchroniser
    task automatic pulse(input bit ext);
        @(posedge clk);
        if (ext)
            external_clock_pin <= 1'b1;
        else
            capture_input_pin <= 1'b1;
        repeat (3) @(posedge clk);
        external_clock_pin <= 1'b0;
        capture_input_pin <= 1'b0;
    endtask : pulse
endmodule : sdt_partner

//--- tb/sdt_top_tb.sv
// self-checking bench for the standard timer
`timescale 1ns/1ps
module sdt_top_tb;
    import sdt_pkg::*;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        capture_input_pin, external_clock_pin, timer_out;
    logic        timer_out_en, ce;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          fails, comparisons, cycles, h0;

    sdt_top dut (.clk, .rst_n, .ce, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .capture_input_pin, .external_clock_pin, .timer_out, .timer_out_en);
    sdt_partner pm (.clk, .timer_out, .timer_out_en, .capture_input_pin,
        .external_clock_pin);

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one write: address and data offered together, answer checked
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        @(posedge clk); // idle edge so a next call never re-raises bready
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        chk(32'(rresp), 32'(er));
        @(posedge clk); // idle edge so a next call never re-raises rready
    endtask : rd

    // stop, clear flags, load compare A, control, then period and run
    task automatic cfg(input logic [7:0] ctl, input logic [2:0] p,
                       input logic [9:0] a, input logic run);
        wr(OFS_CTRL0, 32'h0000_0000);
        wr(OFS_FLAGS, 32'h0000_0003);
        wr(OFS_CMPAL, {24'h00_0000, a[7:0]});
        wr(OFS_CMPAH, {30'h0000_0000, a[9:8]});
        wr(OFS_CTRL1, {24'h00_0000, ctl});
        wr(OFS_CTRL0, {28'h000_0000, run, p});
    endtask : cfg

    task automatic t_regs;
        rd(OFS_CTRL1, v);
        chk(v, 32'h0000_0000);
        wr(OFS_CMPAH, 32'h0000_00FF);
        rd(OFS_CMPAH, v);
        chk(v, 32'h0000_0003);
        wr(8'h40, 32'h0000_0001, RESP_SLV);
        rd(8'h40, v, RESP_SLV);
        chk(v, 32'h0000_0000);
        chk(32'(timer_out_en), 1);
        $display("test regs done");
    endtask : t_regs

    // compare and timer modes: pin level, flags, count bound
    task automatic t_cmp(input logic [7:0] ctl, input logic [2:0] p,
        input logic [9:0] a, input int wt, input logic pin,
        input logic [1:0] fl, input int bound);
        logic en;
        en = (ctl[7:6] != 2'b11);
        cfg(ctl, p, a, 1'b1);
        repeat (5) @(posedge clk);
        chk(32'(timer_out), 32'(en & ctl[3]));
        repeat (wt) @(posedge clk);
        chk(32'(timer_out), 32'(en & pin));
        chk(32'(timer_out_en), 32'(en));
        wr(OFS_CTRL0, 32'h0000_0000);
        rd(OFS_FLAGS, v);
        chk(v, 32'(fl));
        rd(OFS_COUNT, v);
        chk(32'(v < bound), 1);
        $display("test cmp %h done", ctl);
    endtask : t_cmp

    task automatic t_cap;
        for (int fn = 0; fn < 4; fn++) begin
            cfg({2'b01, 2'(fn), 4'h0}, 3'h0, 10'h000, 1'b1);
            repeat (20) @(posedge clk);
            pm.pulse(1'b0);
            repeat (5) @(posedge clk);
            rd(OFS_FLAGS, v);
            chk(v, 32'(fn != 3));
            rd(OFS_CMPAL, v);
            chk(32'(v != 0), 32'(fn != 3));
        end
        cfg(8'h7F, 3'h1, 10'h000, 1'b1);
        repeat (300) @(posedge clk);
        chk(32'(timer_out_en), 0);
        rd(OFS_FLAGS, v);
        chk(v, 32'h0000_0002);
        $display("test capture done");
    endtask : t_cap

    task automatic t_pulse;
        cfg(8'hB8, 3'h0, 10'd40, 1'b0);
        pm.pulse(1'b1);
        repeat (10) @(posedge clk);
        chk(32'(timer_out), 1);
        repeat (100) @(posedge clk);
        chk(32'(timer_out), 0);
        rd(OFS_CTRL0, v);
        chk(32'(v[C0_RUN]), 0);
        rd(OFS_FLAGS, v);
        chk(v, 32'h0000_0001);
        rd(OFS_COUNT, v);
        chk(32'(v != 0), 1);
        $display("test pulse done");
    endtask : t_pulse

    // high cycles of the load over a whole number of periods
    task automatic t_pwm(input logic [7:0] ctl, input logic [9:0] a,
                         input int exp);
        cfg(ctl, 3'h1, a, 1'b1);
        repeat (20) @(posedge clk);
        h0 = pm.high_cnt;
        repeat (512) @(posedge clk);
        chk(32'(pm.high_cnt - h0), 32'(exp));
        $display("test pwm %h done", ctl);
    endtask : t_pwm

    // clock enable low must freeze the running counter
    task automatic t_ce;
        logic [31:0] v0;
        cfg(8'h00, 3'h0, 10'h000, 1'b1);
        rd(OFS_COUNT, v0);
        ce <= 1'b0;
        repeat (50) @(posedge clk);
        ce <= 1'b1;
        rd(OFS_COUNT, v);
        chk(32'(v - v0 < 50), 1);
        $display("test clock enable done");
    endtask : t_ce

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        ce = 1'b1;
        fails = 0;
        comparisons = 0;
        cycles = 0;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_cmp(8'h18, 3'h1, 10'd50, 300, 1'b0, 2'h3, 128);
        t_cmp(8'h21, 3'h1, 10'd300, 700, 1'b1, 2'h1, 300);
        t_cmp(8'h08, 3'h0, 10'd0, 1100, 1'b1, 2'h2, 1024);
        t_cmp(8'h31, 3'h0, 10'd100, 150, 1'b1, 2'h1, 100);
        t_cmp(8'hE8, 3'h1, 10'd50, 300, 1'b0, 2'h3, 128);
        t_cap();
        t_pulse();
        t_pwm(8'hA8, 10'd32, 128);
        t_pwm(8'hA9, 10'd200, 512);
        t_pwm(8'hAA, 10'd256, 256);
        t_pwm(8'h88, 10'd32, 0);
        t_pwm(8'h98, 10'd32, 512);
        t_pwm(8'hAC, 10'd32, 384);
        t_ce();
        end_sim();
    end
endmodule : sdt_top_tb
